// *** hw/tpiop_apb_slave.sv ***
// apb slave phase tracker: one wait-free access cycle
`timescale 1ns/100ps
module tpiop_apb_slave
(
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  output logic                      wr_stb,
  output logic                      rd_stb,
  output tpiop_pkg::tpiop_apb_st_t  state
);
  tpiop_pkg::tpiop_apb_st_t st_r;
  tpiop_pkg::tpiop_apb_st_t st_nxt;
  // ---------------------------------------------------------------
  // phase tracking
  // ---------------------------------------------------------------
  always_comb
  begin
    st_nxt = tpiop_pkg::TPIOP_IDLE;
    case (st_r)
      tpiop_pkg::TPIOP_IDLE:
        st_nxt = psel ? tpiop_pkg::TPIOP_SETUP : tpiop_pkg::TPIOP_IDLE;
      tpiop_pkg::TPIOP_SETUP:
        st_nxt = tpiop_pkg::TPIOP_ACCESS;
      default:
        st_nxt = psel && !penable ? tpiop_pkg::TPIOP_SETUP
                                  : tpiop_pkg::TPIOP_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      st_r <= tpiop_pkg::TPIOP_IDLE;
    else
      st_r <= st_nxt;
  end
  // strobes follow the bus signals so a master needs no wait states
  assign wr_stb = psel && penable && pwrite;
  assign rd_stb = psel && penable && !pwrite;
  assign state  = st_r;
  property p_strobe_excl;
    @(posedge ref_clk) disable iff (!nrst)
    !(wr_stb && rd_stb);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl) // RL14
    else $error("read and write strobe together");
endmodule : tpiop_apb_slave

// *** hw/tpiop_cfg.svh ***
// register offsets, field positions, reset values for the two-pin port
`ifndef TPIOP_CFG_SVH
`define TPIOP_CFG_SVH
`define TPIOP_OFF_DATA     12'h000
`define TPIOP_OFF_DIR      12'h004
`define TPIOP_OFF_PULLUP   12'h008
`define TPIOP_OFF_STBY     12'h00c
`define TPIOP_OFF_PINS     12'h010
`define TPIOP_BIT_LINE_ONE 1
`define TPIOP_BIT_LINE_TWO 2
`define TPIOP_IMPL_MASK    8'h06
`define TPIOP_RST_DATA     8'h00
`define TPIOP_RST_DIR      8'h00
`define TPIOP_RST_PULLUP   8'h00
`define TPIOP_STBY_FLOAT   0
`define TPIOP_STBY_RMW     1
`endif

// *** hw/tpiop_pad_ctrl.sv ***
// pad control: drive, float and pull-up per line
`timescale 1ns/100ps
`include "tpiop_cfg.svh"
module tpiop_pad_ctrl
(
  input  wire logic [1:0]           latch,
  input  wire logic [1:0]           dir,
  input  wire logic [1:0]           pu_en,
  input  wire logic [1:0]           pin_in,
  input  wire logic                 float_now,
  input  wire logic [1:0]           held_out,
  input  wire logic [1:0]           held_oe,
  input  wire logic                 hold_now,
  output tpiop_pkg::tpiop_pad_t     pad,
  output logic      [1:0]           pin_seen
);
  wire [1:0] oe_run  = dir;                               // RL1 RL2
  wire [1:0] oe_eff  = float_now ? 2'b00 :                // RL8
                       hold_now ? held_oe : oe_run;       // RL9
  wire [1:0] out_eff = hold_now ? held_out : latch;       // RL3 RL9
  assign pad.oe  = oe_eff;
  assign pad.out = out_eff;
  // pull-up off when line drives low, and off when floated in standby
  assign pad.pu  = pu_en & ~(oe_eff & ~out_eff)           // RL10 RL11
                   & {2{~float_now}};
  // input forced low in float mode so an open pad cannot leak
  assign pin_seen = float_now ? 2'b00 : pin_in;           // RL8
endmodule : tpiop_pad_ctrl

// *** hw/tpiop_pkg.sv ***
// types for the two-pin port
package tpiop_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] pu_en;
  } tpiop_regs_t;
  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
    logic [1:0] pu;
  } tpiop_pad_t;
  typedef enum logic [1:0] {
    TPIOP_IDLE   = 2'b00,
    TPIOP_SETUP  = 2'b01,
    TPIOP_ACCESS = 2'b11
  } tpiop_apb_st_t;
endpackage : tpiop_pkg

// *** hw/tpiop_port.sv ***
// two-pin general-purpose port with pull-ups, apb register access
//
// How it works
// [RL1] direction bit one makes pin output
// [RL2] direction bit zero makes pin input
// [RL3] output pin drives its latch bit
// [RL4] data writes always load latch
// [RL5] output pin reads back latch
// [RL6] input pin reads pin, rmw reads latch
// [RL7] reset clears direction, all inputs
// [RL8] float mode in standby: hi-z, input low
// [RL9] hold mode in standby keeps pin state
// [RL10] pull-up bit connects pull-up resistor
// [RL11] pull-up cut while pin drives low
// [RL12] only bits two and one exist
// [RL13] software disables shared peripheral outputs first
// [RL14] data, pull-up reset zero; writes next edge
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "tpiop_cfg.svh"
module tpiop_port
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        standby_active,
  input  wire logic [1:0]  port_pin_in,
  output logic      [1:0]  port_pin_out,
  output logic      [1:0]  port_pin_oe,
  output logic      [1:0]  port_pin_pullup
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  tpiop_pkg::tpiop_regs_t   regs_r;
  logic [1:0]               stby_ctl_r;
  logic [1:0]               held_out_r;
  logic [1:0]               held_oe_r;
  logic [31:0]              prdata_r;
  logic                     wr_stb;
  logic                     rd_stb;
  tpiop_pkg::tpiop_apb_st_t bus_st;
  tpiop_pkg::tpiop_pad_t    pad;
  logic [1:0]               pin_seen;

  function automatic logic [7:0] impl_bits(input logic [31:0] d);
    impl_bits = d[7:0] & `TPIOP_IMPL_MASK;                // RL12
  endfunction : impl_bits

  tpiop_apb_slave u_apb
  (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .wr_stb  (wr_stb),
    .rd_stb  (rd_stb),
    .state   (bus_st)
  );

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire sel_data = paddr == `TPIOP_OFF_DATA;
  wire sel_dir  = paddr == `TPIOP_OFF_DIR;
  wire sel_pu   = paddr == `TPIOP_OFF_PULLUP;
  wire sel_stby = paddr == `TPIOP_OFF_STBY;
  wire sel_pins = paddr == `TPIOP_OFF_PINS;
  wire mapped   = sel_data | sel_dir | sel_pu | sel_stby | sel_pins;
  wire float_now = standby_active && stby_ctl_r[`TPIOP_STBY_FLOAT];
  wire hold_now  = standby_active && !stby_ctl_r[`TPIOP_STBY_FLOAT];
  wire rmw_read  = stby_ctl_r[`TPIOP_STBY_RMW];
  wire [1:0] dir2   = {regs_r.dir[`TPIOP_BIT_LINE_TWO],
                       regs_r.dir[`TPIOP_BIT_LINE_ONE]};
  wire [1:0] latch2 = {regs_r.data[`TPIOP_BIT_LINE_TWO],
                       regs_r.data[`TPIOP_BIT_LINE_ONE]};
  wire [1:0] pu2    = {regs_r.pu_en[`TPIOP_BIT_LINE_TWO],
                       regs_r.pu_en[`TPIOP_BIT_LINE_ONE]};
  // rmw flag reads latch everywhere; otherwise output lines read latch
  wire [1:0] rd_lines = rmw_read ? latch2 :               // RL6
                        (dir2 & latch2) | (~dir2 & pin_seen); // RL5 RL6
  wire [7:0] data_rd  = {5'h00, rd_lines, 1'b0};          // RL12
  wire [7:0] pins_rd  = {5'h00, pin_seen, 1'b0};
  wire [7:0] rd_mux   = sel_data ? data_rd :
                        sel_dir  ? regs_r.dir :
                        sel_pu   ? regs_r.pu_en :
                        sel_stby ? {6'h00, stby_ctl_r} :
                        sel_pins ? pins_rd : 8'h00;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      regs_r.data   <= `TPIOP_RST_DATA;                   // RL14
      regs_r.dir    <= `TPIOP_RST_DIR;                    // RL7
      regs_r.pu_en  <= `TPIOP_RST_PULLUP;                 // RL14
      stby_ctl_r    <= 2'h0;
    end
    else if (wr_stb)
    begin
      if (sel_data)
        regs_r.data <= impl_bits(pwdata);                 // RL4 RL14
      if (sel_dir)
        regs_r.dir <= impl_bits(pwdata);                  // RL1 RL2
      if (sel_pu)
        regs_r.pu_en <= impl_bits(pwdata);                // RL10
      if (sel_stby)
        stby_ctl_r <= pwdata[1:0];
    end
  end

  // snapshot of pad drive on standby entry, for hold mode
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      held_out_r <= 2'h0;
      held_oe_r  <= 2'h0;
    end
    else
    begin
      if (!standby_active)
      begin
        held_out_r <= latch2;                             // RL9
        held_oe_r  <= dir2;                               // RL9
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      prdata_r <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_r <= {24'h00_0000, rd_mux};
  end

  // ---------------------------------------------------------------
  // pads
  // ---------------------------------------------------------------
  tpiop_pad_ctrl u_pad
  (
    .latch     (latch2),
    .dir       (dir2),
    .pu_en     (pu2),
    .pin_in    (port_pin_in),
    .float_now (float_now),
    .held_out  (held_out_r),
    .held_oe   (held_oe_r),
    .hold_now  (hold_now),
    .pad       (pad),
    .pin_seen  (pin_seen)
  );

  assign port_pin_out    = pad.out;
  assign port_pin_oe     = pad.oe;
  assign port_pin_pullup = pad.pu;
  assign prdata          = prdata_r;
  assign pready          = 1'b1;
  assign pslverr         = psel && penable && !mapped;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_out_dir;
    @(posedge ref_clk) disable iff (!nrst)
    !standby_active |-> port_pin_oe == dir2;
  endproperty
  a_out_dir: assert property (p_out_dir) // RL1
    else $error("output enable differs from direction");

  property p_in_dir;
    @(posedge ref_clk) disable iff (!nrst)
    !standby_active && !dir2[0] |-> !port_pin_oe[0];
  endproperty
  a_in_dir: assert property (p_in_dir) // RL2
    else $error("input line is driven");

  property p_drive_latch;
    @(posedge ref_clk) disable iff (!nrst)
    !standby_active && dir2[1] |-> port_pin_out[1] == latch2[1];
  endproperty
  a_drive_latch: assert property (p_drive_latch) // RL3
    else $error("output line not showing latch");

  property p_write_lat;
    @(posedge ref_clk) disable iff (!nrst)
    wr_stb && sel_data |=> regs_r.data == $past(impl_bits(pwdata));
  endproperty
  a_write_lat: assert property (p_write_lat) // RL4 RL14
    else $error("data write not latched next edge");

  property p_read_out;
    @(posedge ref_clk) disable iff (!nrst)
    psel && !penable && !pwrite && sel_data && dir2 == 2'b11
      |=> prdata[2:1] == $past(latch2);
  endproperty
  a_read_out: assert property (p_read_out) // RL5
    else $error("output line read not latch");

  property p_read_rmw;
    @(posedge ref_clk) disable iff (!nrst)
    psel && !penable && !pwrite && sel_data && rmw_read
      |=> prdata[2:1] == $past(latch2);
  endproperty
  a_read_rmw: assert property (p_read_rmw) // RL6
    else $error("rmw read not latch");

  property p_float;
    @(posedge ref_clk) disable iff (!nrst)
    float_now |-> port_pin_oe == 2'b00 && pin_seen == 2'b00
                  && port_pin_pullup == 2'b00;
  endproperty
  a_float: assert property (p_float) // RL8
    else $error("float mode not hi-z");

  property p_hold;
    @(posedge ref_clk) disable iff (!nrst)
    !standby_active ##1 hold_now |-> port_pin_out == $past(latch2)
                                     && port_pin_oe == $past(dir2);
  endproperty
  a_hold: assert property (p_hold) // RL9
    else $error("hold mode lost state");

  property p_pull_low;
    @(posedge ref_clk) disable iff (!nrst)
    port_pin_oe[0] && !port_pin_out[0] |-> !port_pin_pullup[0];
  endproperty
  a_pull_low: assert property (p_pull_low) // RL11
    else $error("pull-up on low-driven line");

  property p_pull_low_two;
    @(posedge ref_clk) disable iff (!nrst)
    port_pin_oe[1] && !port_pin_out[1] |-> !port_pin_pullup[1];
  endproperty
  a_pull_low_two: assert property (p_pull_low_two) // RL11
    else $error("pull-up on low-driven line two");

  property p_in_dir_two;
    @(posedge ref_clk) disable iff (!nrst)
    !standby_active && !dir2[1] |-> !port_pin_oe[1];
  endproperty
  a_in_dir_two: assert property (p_in_dir_two) // RL2
    else $error("input line two is driven");

  property p_drive_latch_one;
    @(posedge ref_clk) disable iff (!nrst)
    !standby_active && dir2[0] |-> port_pin_out[0] == latch2[0];
  endproperty
  a_drive_latch_one: assert property (p_drive_latch_one) // RL3
    else $error("line one not showing latch");

  property p_write_dir;
    @(posedge ref_clk) disable iff (!nrst)
    wr_stb && sel_dir |=> regs_r.dir == $past(impl_bits(pwdata));
  endproperty
  a_write_dir: assert property (p_write_dir) // RL1 RL14
    else $error("direction write not taken next edge");

  property p_write_pu;
    @(posedge ref_clk) disable iff (!nrst)
    wr_stb && sel_pu |=> regs_r.pu_en == $past(impl_bits(pwdata));
  endproperty
  a_write_pu: assert property (p_write_pu) // RL10 RL14
    else $error("pull-up write not taken next edge");

  property p_read_in;
    @(posedge ref_clk) disable iff (!nrst)
    psel && !penable && !pwrite && sel_data && !rmw_read && dir2 == 2'b00
      && !float_now |=> prdata[2:1] == $past(port_pin_in);
  endproperty
  a_read_in: assert property (p_read_in) // RL6
    else $error("input line read not pin level");

  property p_pull_on;
    @(posedge ref_clk) disable iff (!nrst)
    !standby_active && pu2[0] && !port_pin_oe[0] |-> port_pin_pullup[0];
  endproperty
  a_pull_on: assert property (p_pull_on) // RL10
    else $error("enabled pull-up not connected");

  property p_pull_off;
    @(posedge ref_clk) disable iff (!nrst)
    pu2 == 2'b00 |-> port_pin_pullup == 2'b00;
  endproperty
  a_pull_off: assert property (p_pull_off) // RL10
    else $error("disabled pull-up connected");

  property p_unmapped;
    @(posedge ref_clk) disable iff (!nrst)
    wr_stb && !mapped |=> $stable(regs_r) && $stable(stby_ctl_r);
  endproperty
  a_unmapped: assert property (p_unmapped) // RL12
    else $error("unmapped write changed a register");

  // tracker trails the bus: access shows one edge after the strobe
  property p_phase;
    @(posedge ref_clk) disable iff (!nrst)
    wr_stb || rd_stb |=> bus_st == tpiop_pkg::TPIOP_ACCESS;
  endproperty
  a_phase: assert property (p_phase) // RL14
    else $error("bus phase tracker out of step");

  property p_unused;
    @(posedge ref_clk) disable iff (!nrst)
    (regs_r.dir & ~`TPIOP_IMPL_MASK) == 8'h00
      && (regs_r.data & ~`TPIOP_IMPL_MASK) == 8'h00
      && (regs_r.pu_en & ~`TPIOP_IMPL_MASK) == 8'h00;
  endproperty
  a_unused: assert property (p_unused) // RL12
    else $error("unused bit set");

  c_write: cover property (@(posedge ref_clk) wr_stb && sel_dir);
  c_float: cover property (@(posedge ref_clk) float_now);
  c_hold:  cover property (@(posedge ref_clk)
                           hold_now && port_pin_oe != 2'b00);
  c_err:   cover property (@(posedge ref_clk) pslverr);
endmodule : tpiop_port

// *** test/test_two_pin_io_port_with_pullup.sv ***
// self-checking bench for the two-pin port
`timescale 1ns/100ps
`include "tpiop_cfg.svh"
module test_two_pin_io_port_with_pullup;
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] dat;
    logic [7:0] pu;
    logic [1:0] ext;
    logic [1:0] oe;
    logic [1:0] out;
    logic [1:0] pul;
    logic [7:0] rd;
  } tpiop_row_t;
  logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        standby_active, e;
  logic [1:0]  port_pin_in, port_pin_out, port_pin_oe, port_pin_pullup;
  logic [1:0]  ext_val, ext_en;
  int          err_count, num_checks;
  tpiop_row_t  rows [5] = '{
    '{8'h00, 8'h06, 8'h00, 2'b01, 2'b00, 2'b00, 2'b00, 8'h02},
    '{8'h06, 8'h04, 8'h06, 2'b00, 2'b11, 2'b10, 2'b10, 8'h04},
    '{8'h02, 8'hff, 8'h06, 2'b00, 2'b01, 2'b01, 2'b11, 8'h02},
    '{8'hff, 8'h00, 8'hff, 2'b11, 2'b11, 2'b00, 2'b00, 8'h00},
    '{8'h04, 8'h00, 8'h02, 2'b01, 2'b10, 2'b00, 2'b01, 8'h02}};
  tpiop_port dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .standby_active(standby_active), .port_pin_in(port_pin_in),
    .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
    .port_pin_pullup(port_pin_pullup));
  tpiop_pin_model board (.ref_clk(ref_clk), .pin_out(port_pin_out),
    .pin_oe(port_pin_oe), .pin_pu(port_pin_pullup), .ext_val(ext_val),
    .ext_en(ext_en), .pin_in(port_pin_in));
  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task close_out;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  task chk32(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask : chk32
  task chk2(input string n, input logic [1:0] x, input logic [1:0] g);
    num_checks++;
    if (g !== x)
    begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", n, x, g);
    end
  endtask : chk2
  // request held until pready is seen at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      err_count++;
      close_out();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr
  task rdc(input string n, input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h0);
    chk32(n, {24'h0, x}, q);
  endtask : rdc
  task settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle
  // ----------------------------------------
  // clock and main sequence
  // ----------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    {nrst, psel, penable, pwrite, standby_active} = 5'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ext_val = 2'b00;
    ext_en = 2'b11;
    err_count = 0;
    num_checks = 0;
    repeat (20) @(posedge ref_clk);
    chk2("oe_rst", 2'b00, port_pin_oe);
    chk2("pu_rst", 2'b00, port_pin_pullup);
    nrst <= 1'b1;
    rdc("dir_rst", `TPIOP_OFF_DIR, 8'h00);
    rdc("pu_rst_r", `TPIOP_OFF_PULLUP, 8'h00);
    rdc("stby_rst", `TPIOP_OFF_STBY, 8'h00);
    wr(`TPIOP_OFF_STBY, 8'h02);
    rdc("dat_rst", `TPIOP_OFF_DATA, 8'h00);
    wr(`TPIOP_OFF_STBY, 8'h00);
    foreach (rows[i])
    begin
      ext_val <= rows[i].ext;
      wr(`TPIOP_OFF_DIR, rows[i].dir);
      wr(`TPIOP_OFF_DATA, rows[i].dat);
      wr(`TPIOP_OFF_PULLUP, rows[i].pu);
      settle();
      chk2("oe", rows[i].oe, port_pin_oe);
      chk2("out", rows[i].out, port_pin_out & port_pin_oe);
      chk2("pull", rows[i].pul, port_pin_pullup);
      rdc("dat", `TPIOP_OFF_DATA, rows[i].rd);
      rdc("dir", `TPIOP_OFF_DIR, rows[i].dir & `TPIOP_IMPL_MASK);
    end
    // latch loaded while input, seen only by an rmw-style read
    wr(`TPIOP_OFF_DIR, 8'h00);
    wr(`TPIOP_OFF_DATA, 8'h06);
    ext_val <= 2'b00;
    wr(`TPIOP_OFF_STBY, 8'h02);
    rdc("rmw", `TPIOP_OFF_DATA, 8'h06);
    rdc("pins", `TPIOP_OFF_PINS, 8'h00);
    wr(`TPIOP_OFF_STBY, 8'h01);
    wr(`TPIOP_OFF_DIR, 8'h06);
    wr(`TPIOP_OFF_PULLUP, 8'h06);
    // float mode: line left open so a leaky input would show
    ext_en <= 2'b00;
    standby_active <= 1'b1;
    settle();
    chk2("oe_flt", 2'b00, port_pin_oe);
    chk2("pu_flt", 2'b00, port_pin_pullup);
    rdc("pin_flt", `TPIOP_OFF_PINS, 8'h00);
    standby_active <= 1'b0;
    ext_en <= 2'b11;
    wr(`TPIOP_OFF_STBY, 8'h00);
    wr(`TPIOP_OFF_DATA, 8'h02);
    settle();
    @(posedge ref_clk);
    standby_active <= 1'b1;
    wr(`TPIOP_OFF_DATA, 8'h04);
    settle();
    chk2("oe_hold", 2'b11, port_pin_oe);
    chk2("out_hold", 2'b01, port_pin_out);
    @(posedge ref_clk);
    standby_active <= 1'b0;
    settle();
    chk2("out_wake", 2'b10, port_pin_out);
    apb(1'b0, 12'h020, 32'h0);
    chk32("unm_rd", 32'h0, q);
    chk2("unm_err", 2'b01, {1'b0, e});
    wr(12'h020, 8'hff);
    rdc("dir_kept", `TPIOP_OFF_DIR, 8'h06);
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    rdc("dir_rst2", `TPIOP_OFF_DIR, 8'h00);
    rdc("pu_rst2", `TPIOP_OFF_PULLUP, 8'h00);
    close_out();
  end
endmodule : test_two_pin_io_port_with_pullup

// *** test/tpiop_pin_model.sv ***
// board side of the two port lines: external drivers and pull-ups
`timescale 1ns/100ps
module tpiop_pin_model
(
  input  wire logic       ref_clk,
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe,
  input  wire logic [1:0] pin_pu,
  input  wire logic [1:0] ext_val,
  input  wire logic [1:0] ext_en,
  output logic      [1:0] pin_in
);
  // ----------------------------------------
  // line levels
  // ----------------------------------------
  // undriven line with no pull-up wanders, so no read may rely on it
  logic [1:0] wander_r = 2'b01;
  always @(posedge ref_clk)
  begin
    wander_r <= ~wander_r;
  end
  // oscillator side never drives, shared outputs kept off
  assign pin_in = (pin_oe & pin_out)
                | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & pin_pu)
                | (~pin_oe & ~ext_en & ~pin_pu & wander_r);
endmodule : tpiop_pin_model
